// file: rtl/tes_pkg.sv
// shared constants and carrier types for the touch expander system registers
package tes_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses, msb of wide regs at offset)
    // ------------------------------------------------------------
    localparam logic [6:0] OFS_DEVICE_IDENTITY = 7'h00;
    localparam logic [6:0] OFS_SILICON_REVISION = 7'h02;
    localparam logic [6:0] OFS_RESET_SLEEP = 7'h03;
    localparam logic [6:0] OFS_CLOCK_GATING = 7'h04;
    localparam logic [6:0] OFS_SERIAL_CFG = 7'h08;
    localparam logic [6:0] OFS_ANALOG_CH4 = 7'h38;
    localparam logic [6:0] OFS_ANALOG_CH5 = 7'h3a;
    localparam logic [6:0] OFS_ANALOG_CH6 = 7'h3c;
    localparam logic [6:0] OFS_ANALOG_CH7 = 7'h3e;
    localparam logic [6:0] OFS_TOUCH_SETUP = 7'h40;
    localparam logic [6:0] OFS_TOUCH_CONFIG = 7'h41;
    localparam logic [6:0] OFS_WIN_UR_X = 7'h42;
    localparam logic [6:0] OFS_WIN_UR_Y = 7'h44;
    localparam logic [6:0] OFS_WIN_LL_X = 7'h46;
    localparam logic [6:0] OFS_WIN_LL_Y = 7'h48;
    localparam logic [6:0] OFS_BUF_THRESHOLD = 7'h4a;
    localparam logic [6:0] OFS_BUF_STATE = 7'h4b;
    localparam logic [6:0] OFS_BUF_FILL = 7'h4c;
    localparam logic [6:0] OFS_SAMPLE_X = 7'h4d;
    localparam logic [6:0] OFS_SAMPLE_Y = 7'h4f;
    localparam logic [6:0] OFS_SAMPLE_Z = 7'h51;
    localparam logic [6:0] OFS_SAMPLE_PACKED = 7'h52;
    localparam logic [6:0] OFS_PRESSURE_FRAC = 7'h56;
    localparam logic [6:0] OFS_SAMPLE_BYTE = 7'h57;
    localparam logic [6:0] OFS_DRIVE_CURRENT = 7'h58;
    localparam logic [6:0] OFS_SHIELD_CTRL = 7'h59;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_FORCED_SLEEP = 0;
    localparam int BIT_SOFT_RESET = 1;
    localparam int BIT_ADC_GATE = 0;
    localparam int BIT_TOUCH_GATE = 1;
    localparam int BIT_GPIO_GATE = 2;
    localparam int BIT_TEMP_GATE = 3;
    localparam int BIT_AUTO_INCR = 2;
    localparam int BIT_TOUCH_ENABLE = 0;

    // ------------------------------------------------------------
    // reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_RESET_SLEEP = 8'h00;
    localparam logic [7:0] RST_CLOCK_GATING = 8'h0f;
    localparam logic [7:0] RST_SERIAL_CFG = 8'h01;
    localparam logic [7:0] RST_TOUCH_SETUP = 8'h90;
    localparam logic [7:0] RST_TOUCH_CONFIG = 8'h00;
    localparam logic [15:0] RST_WIN_UPPER = 16'h0fff;
    localparam logic [15:0] RST_WIN_LOWER = 16'h0000;
    localparam logic [7:0] RST_BUF_THRESHOLD = 8'h00;
    localparam logic [7:0] RST_BUF_STATE = 8'h20;
    localparam logic [7:0] RST_PRESSURE_FRAC = 8'h00;
    localparam logic [7:0] RST_DRIVE_CURRENT = 8'h00;
    localparam logic [7:0] RST_SHIELD_CTRL = 8'h00;
    localparam logic [7:0] MASK_RESET_SLEEP = 8'h03;
    localparam logic [7:0] MASK_CLOCK_GATING = 8'h0f;
    localparam logic [7:0] MASK_SERIAL_CFG = 8'h07;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic start;
        logic [6:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } tes_host_req_type;

    typedef struct packed {
        logic rvalid;
        logic [7:0] rdata;
    } tes_host_rsp_type;

    typedef struct packed {
        logic [15:0] ch4;
        logic [15:0] ch5;
        logic [15:0] ch6;
        logic [15:0] ch7;
    } tes_analog_type;

    typedef struct packed {
        logic [7:0] buf_state;
        logic [7:0] buf_fill;
        logic [15:0] x;
        logic [15:0] y;
        logic [7:0] z;
        logic [31:0] packed_xyz;
        logic [7:0] byte_data;
    } tes_touch_in_type;

    typedef struct packed {
        logic [7:0] setup;
        logic [7:0] config_val;
        logic [15:0] win_ur_x;
        logic [15:0] win_ur_y;
        logic [15:0] win_ll_x;
        logic [15:0] win_ll_y;
        logic [7:0] threshold;
        logic [7:0] frac_select;
        logic [7:0] drive_current;
        logic [7:0] shield;
    } tes_touch_cfg_type;
endpackage

// file: rtl/tes_system_regs.sv
// system control and register map for the touch expander
`timescale 1ns/1ps
module tes_system_regs #(
    // arbitrary value
    parameter logic [15:0] IDENTITY_CODE = 16'h5a3c,
    // arbitrary value
    parameter logic [7:0] REVISION_CODE = 8'h07
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire tes_pkg::tes_host_req_type host_req,
    output tes_pkg::tes_host_rsp_type host_rsp,
    input wire tes_pkg::tes_analog_type analog_in,
    input wire tes_pkg::tes_touch_in_type touch_in,
    output tes_pkg::tes_touch_cfg_type touch_cfg,
    output logic touch_run,
    output logic [3:0] unit_clock_enable,
    output logic forced_sleep,
    output logic hotkey_wake_enable,
    output logic soft_reset_pulse,
    output logic buffer_state_wr,
    output logic [7:0] buffer_state_wdata,
    output logic sample_byte_pop
);
    import tes_pkg::*;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_r;
    logic rst_sync_n_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n_r <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [6:0] ptr;
        logic [7:0] reset_sleep;
        logic [7:0] clock_gating;
        logic [7:0] serial_cfg;
        tes_touch_cfg_type cfg;
        tes_host_rsp_type rsp;
        logic touch_run;
        logic [3:0] unit_en;
        logic hotkey_en;
        logic soft_pulse;
        logic bs_wr;
        logic [7:0] bs_wdata;
        logic pop;
    } tes_state_type;

    tes_state_type st_r;
    tes_state_type st_nxt;
    tes_state_type st_rst;
    logic [6:0] acc_addr;
    logic [7:0] rd_byte;
    logic auto_incr;

    always_comb begin
        st_rst = '0;
        st_rst.reset_sleep = RST_RESET_SLEEP;
        st_rst.clock_gating = RST_CLOCK_GATING;
        st_rst.serial_cfg = RST_SERIAL_CFG;
        st_rst.cfg.setup = RST_TOUCH_SETUP;
        st_rst.cfg.config_val = RST_TOUCH_CONFIG;
        st_rst.cfg.win_ur_x = RST_WIN_UPPER;
        st_rst.cfg.win_ur_y = RST_WIN_UPPER;
        st_rst.cfg.win_ll_x = RST_WIN_LOWER;
        st_rst.cfg.win_ll_y = RST_WIN_LOWER;
        st_rst.cfg.threshold = RST_BUF_THRESHOLD;
        st_rst.cfg.frac_select = RST_PRESSURE_FRAC;
        st_rst.cfg.drive_current = RST_DRIVE_CURRENT;
        st_rst.cfg.shield = RST_SHIELD_CTRL;
        st_rst.bs_wdata = RST_BUF_STATE;
        st_rst.hotkey_en = 1'b1;
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // start byte carries address
    assign acc_addr = host_req.start ? host_req.addr : st_r.ptr;
    assign auto_incr = st_r.serial_cfg[BIT_AUTO_INCR];

    always_comb begin
        rd_byte = 8'h00;
        unique case (acc_addr)
            OFS_DEVICE_IDENTITY: rd_byte = IDENTITY_CODE[15:8];
            OFS_DEVICE_IDENTITY + 7'd1: rd_byte = IDENTITY_CODE[7:0];
            OFS_SILICON_REVISION: rd_byte = REVISION_CODE;
            OFS_RESET_SLEEP: rd_byte = st_r.reset_sleep;
            OFS_CLOCK_GATING: rd_byte = st_r.clock_gating;
            OFS_SERIAL_CFG: rd_byte = st_r.serial_cfg;
            OFS_ANALOG_CH4: rd_byte = analog_in.ch4[15:8];
            OFS_ANALOG_CH4 + 7'd1: rd_byte = analog_in.ch4[7:0];
            OFS_ANALOG_CH5: rd_byte = analog_in.ch5[15:8];
            OFS_ANALOG_CH5 + 7'd1: rd_byte = analog_in.ch5[7:0];
            OFS_ANALOG_CH6: rd_byte = analog_in.ch6[15:8];
            OFS_ANALOG_CH6 + 7'd1: rd_byte = analog_in.ch6[7:0];
            OFS_ANALOG_CH7: rd_byte = analog_in.ch7[15:8];
            OFS_ANALOG_CH7 + 7'd1: rd_byte = analog_in.ch7[7:0];
            OFS_TOUCH_SETUP: rd_byte = st_r.cfg.setup;
            OFS_TOUCH_CONFIG: rd_byte = st_r.cfg.config_val;
            OFS_WIN_UR_X: rd_byte = st_r.cfg.win_ur_x[15:8];
            OFS_WIN_UR_X + 7'd1: rd_byte = st_r.cfg.win_ur_x[7:0];
            OFS_WIN_UR_Y: rd_byte = st_r.cfg.win_ur_y[15:8];
            OFS_WIN_UR_Y + 7'd1: rd_byte = st_r.cfg.win_ur_y[7:0];
            OFS_WIN_LL_X: rd_byte = st_r.cfg.win_ll_x[15:8];
            OFS_WIN_LL_X + 7'd1: rd_byte = st_r.cfg.win_ll_x[7:0];
            OFS_WIN_LL_Y: rd_byte = st_r.cfg.win_ll_y[15:8];
            OFS_WIN_LL_Y + 7'd1: rd_byte = st_r.cfg.win_ll_y[7:0];
            OFS_BUF_THRESHOLD: rd_byte = st_r.cfg.threshold;
            OFS_BUF_STATE: rd_byte = touch_in.buf_state;
            OFS_BUF_FILL: rd_byte = touch_in.buf_fill;
            OFS_SAMPLE_X: rd_byte = touch_in.x[15:8];
            OFS_SAMPLE_X + 7'd1: rd_byte = touch_in.x[7:0];
            OFS_SAMPLE_Y: rd_byte = touch_in.y[15:8];
            OFS_SAMPLE_Y + 7'd1: rd_byte = touch_in.y[7:0];
            OFS_SAMPLE_Z: rd_byte = touch_in.z;
            OFS_SAMPLE_PACKED: rd_byte = touch_in.packed_xyz[31:24];
            OFS_SAMPLE_PACKED + 7'd1: rd_byte = touch_in.packed_xyz[23:16];
            OFS_SAMPLE_PACKED + 7'd2: rd_byte = touch_in.packed_xyz[15:8];
            OFS_SAMPLE_PACKED + 7'd3: rd_byte = touch_in.packed_xyz[7:0];
            OFS_PRESSURE_FRAC: rd_byte = st_r.cfg.frac_select;
            OFS_SAMPLE_BYTE: rd_byte = touch_in.byte_data;
            OFS_DRIVE_CURRENT: rd_byte = st_r.cfg.drive_current;
            OFS_SHIELD_CTRL: rd_byte = st_r.cfg.shield;
            default: rd_byte = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.rsp.rvalid = 1'b0;
        st_nxt.soft_pulse = 1'b0;
        st_nxt.bs_wr = 1'b0;
        st_nxt.pop = 1'b0;
        if (host_req.start) begin
            st_nxt.ptr = host_req.addr;
        end
        if (host_req.rd) begin
            st_nxt.rsp.rvalid = 1'b1;
            st_nxt.rsp.rdata = rd_byte;
            st_nxt.pop = (acc_addr == OFS_SAMPLE_BYTE);
        end else if (host_req.wr) begin
            unique case (acc_addr)
                OFS_RESET_SLEEP: begin
                    st_nxt.reset_sleep = host_req.wdata & MASK_RESET_SLEEP;
                end
                OFS_CLOCK_GATING: begin
                    st_nxt.clock_gating =
                        host_req.wdata & MASK_CLOCK_GATING;
                end
                OFS_SERIAL_CFG: begin
                    st_nxt.serial_cfg = host_req.wdata & MASK_SERIAL_CFG;
                end
                OFS_TOUCH_SETUP: st_nxt.cfg.setup = host_req.wdata;
                OFS_TOUCH_CONFIG: st_nxt.cfg.config_val = host_req.wdata;
                OFS_WIN_UR_X: st_nxt.cfg.win_ur_x[15:8] = host_req.wdata;
                OFS_WIN_UR_X + 7'd1: begin
                    st_nxt.cfg.win_ur_x[7:0] = host_req.wdata;
                end
                OFS_WIN_UR_Y: st_nxt.cfg.win_ur_y[15:8] = host_req.wdata;
                OFS_WIN_UR_Y + 7'd1: begin
                    st_nxt.cfg.win_ur_y[7:0] = host_req.wdata;
                end
                OFS_WIN_LL_X: st_nxt.cfg.win_ll_x[15:8] = host_req.wdata;
                OFS_WIN_LL_X + 7'd1: begin
                    st_nxt.cfg.win_ll_x[7:0] = host_req.wdata;
                end
                OFS_WIN_LL_Y: st_nxt.cfg.win_ll_y[15:8] = host_req.wdata;
                OFS_WIN_LL_Y + 7'd1: begin
                    st_nxt.cfg.win_ll_y[7:0] = host_req.wdata;
                end
                OFS_BUF_THRESHOLD: st_nxt.cfg.threshold = host_req.wdata;
                // buffer unit owns the state, we only pass the write on
                OFS_BUF_STATE: begin
                    st_nxt.bs_wr = 1'b1;
                    st_nxt.bs_wdata = host_req.wdata;
                end
                OFS_PRESSURE_FRAC: st_nxt.cfg.frac_select = host_req.wdata;
                OFS_DRIVE_CURRENT: st_nxt.cfg.drive_current = host_req.wdata;
                OFS_SHIELD_CTRL: st_nxt.cfg.shield = host_req.wdata;
                default: begin
                end
            endcase
        end
        if ((host_req.rd || host_req.wr) && auto_incr) begin
            st_nxt.ptr = acc_addr + 7'd1;
        end else if (host_req.rd || host_req.wr) begin
            st_nxt.ptr = acc_addr;
        end
        st_nxt.hotkey_en = ~st_nxt.reset_sleep[BIT_FORCED_SLEEP];
        // one in a gate bit stops clock
        st_nxt.unit_en = ~st_nxt.clock_gating[3:0];
        st_nxt.touch_run = st_nxt.cfg.setup[BIT_TOUCH_ENABLE] &
            ~st_nxt.clock_gating[BIT_TOUCH_GATE];
        if (st_nxt.reset_sleep[BIT_SOFT_RESET]) begin
            st_nxt = st_rst;
            st_nxt.soft_pulse = 1'b1;
            st_nxt.unit_en = ~RST_CLOCK_GATING[3:0];
        end
    end

    // soft reset also goes out as soft_reset_pulse so the other units follow
    always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            st_r <= '0;
            st_r.reset_sleep <= RST_RESET_SLEEP;
            st_r.clock_gating <= RST_CLOCK_GATING;
            st_r.serial_cfg <= RST_SERIAL_CFG;
            st_r.cfg.setup <= RST_TOUCH_SETUP;
            st_r.cfg.win_ur_x <= RST_WIN_UPPER;
            st_r.cfg.win_ur_y <= RST_WIN_UPPER;
            st_r.bs_wdata <= RST_BUF_STATE;
            st_r.hotkey_en <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign host_rsp = st_r.rsp;
    assign touch_cfg = st_r.cfg;
    assign touch_run = st_r.touch_run;
    assign unit_clock_enable = st_r.unit_en;
    assign forced_sleep = st_r.reset_sleep[BIT_FORCED_SLEEP];
    assign hotkey_wake_enable = st_r.hotkey_en;
    assign soft_reset_pulse = st_r.soft_pulse;
    assign buffer_state_wr = st_r.bs_wr;
    assign buffer_state_wdata = st_r.bs_wdata;
    assign sample_byte_pop = st_r.pop;
endmodule

// file: tb/tes_asserts.sv
// port-level checks for the system register block
`timescale 1ns/1ps
module tes_asserts (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire tes_pkg::tes_host_req_type host_req,
    input wire tes_pkg::tes_host_rsp_type host_rsp,
    input wire tes_pkg::tes_touch_cfg_type touch_cfg,
    input wire logic touch_run,
    input wire logic [3:0] unit_clock_enable,
    input wire logic forced_sleep,
    input wire logic hotkey_wake_enable,
    input wire logic soft_reset_pulse,
    input wire logic buffer_state_wr,
    input wire logic [7:0] buffer_state_wdata,
    input wire logic sample_byte_pop
);
    import tes_pkg::*;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    // only start-qualified requests, the pointer is not visible here
    logic wr_at;
    logic rd_at;
    assign wr_at = host_req.start && host_req.wr && !host_req.rd;
    assign rd_at = host_req.start && host_req.rd;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    a_read_answer:
        assert property (host_req.rd |=> host_rsp.rvalid)
        else $error("read not answered in one cycle");
    a_sleep_follows:
        assert property (wr_at && host_req.addr == OFS_RESET_SLEEP &&
            !host_req.wdata[BIT_SOFT_RESET] |=>
            forced_sleep == $past(host_req.wdata[BIT_FORCED_SLEEP]))
        else $error("forced sleep does not follow write");
    a_sleep_hotkey:
        assert property (hotkey_wake_enable == !forced_sleep)
        else $error("hot-key wake on during forced sleep");
    a_gate_follows:
        assert property (wr_at && host_req.addr == OFS_CLOCK_GATING |=>
            unit_clock_enable == ~$past(host_req.wdata[3:0]))
        else $error("clock enables do not follow gating write");
    a_touch_gated:
        assert property (!unit_clock_enable[BIT_TOUCH_GATE] |-> !touch_run)
        else $error("touch unit runs while gated");
    a_soft_pulse:
        assert property (wr_at && host_req.addr == OFS_RESET_SLEEP &&
            host_req.wdata[BIT_SOFT_RESET] |=>
            soft_reset_pulse ##1 !soft_reset_pulse)
        else $error("soft reset pulse wrong");
    a_soft_defaults:
        assert property (soft_reset_pulse |-> unit_clock_enable == 4'h0 &&
            !forced_sleep && touch_cfg.setup == RST_TOUCH_SETUP &&
            touch_cfg.win_ur_x == RST_WIN_UPPER)
        else $error("state not at defaults on soft reset");
    a_state_forward:
        assert property (wr_at && host_req.addr == OFS_BUF_STATE |=>
            buffer_state_wr && buffer_state_wdata == $past(host_req.wdata))
        else $error("buffer state write not forwarded");
    a_pop_on_read:
        assert property (rd_at && host_req.addr == OFS_SAMPLE_BYTE |=>
            sample_byte_pop)
        else $error("byte port read does not pop");
    a_pop_needs_read:
        assert property (sample_byte_pop |-> $past(host_req.rd))
        else $error("pop without a read");
endmodule

// file: tb/tes_host_model.sv
// host model issuing byte requests to the register block
`timescale 1ns/1ps
module tes_host_model (
    input wire logic clk_sys,
    output tes_pkg::tes_host_req_type host_req,
    input wire tes_pkg::tes_host_rsp_type host_rsp
);
    import tes_pkg::*;
    initial host_req = '0;
    // one request per cycle, driven just after the edge
    task automatic op(input logic s, input logic [6:0] a, input logic w,
        input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        host_req = '{start: s, addr: a, wr: w, rd: !w, wdata: d};
    endtask
    task automatic idle();
        @(posedge clk_sys);
        #1;
        host_req = '0;
    endtask
    task automatic wr_seq(input logic [6:0] a, input int n,
        input logic [31:0] v);
        for (int i = 0; i < n; i++) begin
            op(i == 0, a, 1'b1, v[8 * (n - 1 - i) +: 8]);
        end
        idle();
    endtask
    // answer of each read lands while the next one is issued
    task automatic rd_seq(input logic [6:0] a, input int n,
        output logic [31:0] v);
        v = '0;
        for (int i = 0; i < n; i++) begin
            op(i == 0, a, 1'b0, 8'h00);
            if (i > 0) begin
                v = {v[23:0], host_rsp.rdata};
            end
        end
        idle();
        v = {v[23:0], host_rsp.rdata};
    endtask
endmodule

// file: tb/tb.sv
// self-checking bench for the touch expander system registers
`timescale 1ns/1ps
module tb;
    import tes_pkg::*;
    // arbitrary identity values
    localparam logic [15:0] ID_CODE = 16'h3c96;
    localparam logic [7:0] REV_CODE = 8'h5e;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    tes_host_req_type host_req;
    tes_host_rsp_type host_rsp;
    tes_analog_type analog_in = '0;
    tes_touch_in_type touch_in = '0;
    tes_touch_cfg_type touch_cfg;
    logic touch_run;
    logic [3:0] unit_clock_enable;
    logic forced_sleep;
    logic hotkey_wake_enable;
    logic soft_reset_pulse;
    logic buffer_state_wr;
    logic [7:0] buffer_state_wdata;
    logic sample_byte_pop;
    logic [31:0] v;
    int num_errors = 0;
    int checks = 0;
    always #2.5 clk_sys = ~clk_sys;
    tes_system_regs #(.IDENTITY_CODE(ID_CODE), .REVISION_CODE(REV_CODE))
        i_tes_system_regs (.clk_sys(clk_sys), .rst_n(rst_n),
        .host_req(host_req), .host_rsp(host_rsp), .analog_in(analog_in),
        .touch_in(touch_in), .touch_cfg(touch_cfg), .touch_run(touch_run),
        .unit_clock_enable(unit_clock_enable), .forced_sleep(forced_sleep),
        .hotkey_wake_enable(hotkey_wake_enable),
        .soft_reset_pulse(soft_reset_pulse),
        .buffer_state_wr(buffer_state_wr),
        .buffer_state_wdata(buffer_state_wdata),
        .sample_byte_pop(sample_byte_pop));
    tes_host_model i_tes_host_model (.clk_sys(clk_sys),
        .host_req(host_req), .host_rsp(host_rsp));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [6:0] a, input int n, input logic [31:0] d);
        i_tes_host_model.wr_seq(a, n, d);
    endtask
    task automatic rd(input logic [6:0] a, input int n);
        i_tes_host_model.rd_seq(a, n, v);
    endtask
    // levels may settle one cycle after the write
    task automatic wait1();
        i_tes_host_model.idle();
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [6:0] ra [10] = '{7'h03, 7'h04, 7'h08, 7'h40, 7'h41, 7'h4a,
            7'h4c, 7'h56, 7'h58, 7'h59};
        logic [7:0] rv [10] = '{8'h00, 8'h0f, 8'h01, 8'h90, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00};
        chk("clk_en", 4'h0, unit_clock_enable);
        chk("hotkey", 1'b1, hotkey_wake_enable);
        chk("state_wdata", 8'h20, buffer_state_wdata);
        chk("ur_y", 16'h0fff, touch_cfg.win_ur_y);
        chk("ll_x", 16'h0000, touch_cfg.win_ll_x);
        for (int i = 0; i < 10; i++) begin
            rd(ra[i], 1);
            chk("reset value", rv[i], v);
        end
    endtask
    task automatic t_ident();
        wr(OFS_SERIAL_CFG, 1, 8'h05);
        rd(OFS_DEVICE_IDENTITY, 2);
        chk("identity", ID_CODE, v);
        rd(OFS_SILICON_REVISION, 1);
        chk("revision", REV_CODE, v);
        wr(OFS_DEVICE_IDENTITY, 3, 32'h00ff_ffff);
        rd(OFS_DEVICE_IDENTITY, 3);
        chk("ro ident", {ID_CODE, REV_CODE}, v);
        wr(OFS_SERIAL_CFG, 1, 8'hfd);
        rd(OFS_SERIAL_CFG, 1);
        chk("reserved", 8'h05, v);
        wr(7'h05, 1, 8'haa);
        rd(7'h05, 1);
        chk("unmapped", 8'h00, v);
    endtask
    task automatic t_window();
        wr(OFS_WIN_UR_X, 4, 32'h0123_4567);
        wr(OFS_WIN_LL_X, 4, 32'h089a_0bcd);
        wr(OFS_BUF_THRESHOLD, 1, 8'h3c);
        wr(OFS_PRESSURE_FRAC, 1, 8'hc5);
        wr(OFS_TOUCH_CONFIG, 1, 8'h3d);
        wr(OFS_DRIVE_CURRENT, 2, 32'h0000_5aa5);
        wait1();
        chk("config", 8'h3d, touch_cfg.config_val);
        chk("drive", 8'h5a, touch_cfg.drive_current);
        chk("shield", 8'ha5, touch_cfg.shield);
        chk("ur_x", 16'h0123, touch_cfg.win_ur_x);
        chk("ur_y", 16'h4567, touch_cfg.win_ur_y);
        chk("ll_x", 16'h089a, touch_cfg.win_ll_x);
        chk("ll_y", 16'h0bcd, touch_cfg.win_ll_y);
        chk("threshold", 8'h3c, touch_cfg.threshold);
        chk("frac", 8'hc5, touch_cfg.frac_select);
        rd(OFS_WIN_LL_X, 4);
        chk("ll read", 32'h089a_0bcd, v);
        rd(OFS_PRESSURE_FRAC, 1);
        chk("frac read", 8'hc5, v);
        rd(OFS_DRIVE_CURRENT, 2);
        chk("drive read", 16'h5aa5, v);
    endtask
    task automatic t_ports();
        analog_in.ch4 = 16'h1a2b;
        analog_in.ch7 = 16'h3c4d;
        touch_in = '{8'h11, 8'h07, 16'h0abc, 16'h0def, 8'h5f,
            32'habcd_ef12, 8'h6e};
        rd(OFS_ANALOG_CH4, 2);
        chk("ch4", 16'h1a2b, v);
        rd(OFS_ANALOG_CH7, 2);
        chk("ch7", 16'h3c4d, v);
        rd(OFS_SAMPLE_X, 4);
        chk("xy", 32'h0abc_0def, v);
        rd(OFS_SAMPLE_Z, 1);
        chk("z", 8'h5f, v);
        rd(OFS_SAMPLE_PACKED, 4);
        chk("xyz", 32'habcd_ef12, v);
        wr(OFS_BUF_FILL, 1, 8'hff);
        rd(OFS_BUF_FILL, 1);
        chk("fill", 8'h07, v);
        rd(OFS_BUF_STATE, 1);
        chk("state", 8'h11, v);
        rd(OFS_SAMPLE_BYTE, 1);
        chk("byte", 8'h6e, v);
        chk("pop", 1'b1, sample_byte_pop);
        wr(OFS_BUF_STATE, 1, 8'h77);
        chk("state_wr", 1'b1, buffer_state_wr);
        chk("state_wdata", 8'h77, buffer_state_wdata);
    endtask
    task automatic t_gating();
        wr(OFS_TOUCH_SETUP, 1, 8'h91);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CLOCK_GATING, 1, 8'h0f ^ (8'h01 << i));
            wait1();
            chk("clk_en", 4'h1 << i, unit_clock_enable);
            chk("touch_run", i == 1, touch_run);
        end
        wr(OFS_CLOCK_GATING, 1, 8'hf0);
        rd(OFS_CLOCK_GATING, 1);
        chk("gating", 8'h00, v);
        wr(OFS_CLOCK_GATING, 1, 8'h02);
        wait1();
        chk("gated run", 1'b0, touch_run);
    endtask
    task automatic t_sleep();
        wr(OFS_RESET_SLEEP, 1, 8'h01);
        wait1();
        chk("sleep", 1'b1, forced_sleep);
        chk("hotkey", 1'b0, hotkey_wake_enable);
        wr(OFS_RESET_SLEEP, 1, 8'h00);
        wait1();
        chk("awake hotkey", 1'b1, hotkey_wake_enable);
    endtask
    task automatic t_soft();
        wr(OFS_RESET_SLEEP, 1, 8'h02);
        chk("soft pulse", 1'b1, soft_reset_pulse);
        wait1();
        chk("threshold", 8'h00, touch_cfg.threshold);
        chk("ur_x", 16'h0fff, touch_cfg.win_ur_x);
        chk("clk_en", 4'h0, unit_clock_enable);
        rd(OFS_SERIAL_CFG, 1);
        chk("serial cfg", 8'h01, v);
        rd(OFS_RESET_SLEEP, 1);
        chk("bit clear", 8'h00, v);
        rd(OFS_DEVICE_IDENTITY, 2);
        chk("no incr", {ID_CODE[15:8], ID_CODE[15:8]}, v);
    endtask
    task automatic wrap_up();
        if (num_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        t_reset();
        t_ident();
        t_window();
        t_ports();
        t_gating();
        t_sleep();
        t_soft();
        wrap_up();
    end
    // run needs well under two thousand cycles
    initial begin
        #50000;
        num_errors++;
        wrap_up();
    end
endmodule
bind tes_system_regs tes_asserts i_tes_asserts (.clk_sys(clk_sys),
    .rst_n(rst_n), .host_req(host_req), .host_rsp(host_rsp),
    .touch_cfg(touch_cfg), .touch_run(touch_run),
    .unit_clock_enable(unit_clock_enable), .forced_sleep(forced_sleep),
    .hotkey_wake_enable(hotkey_wake_enable),
    .soft_reset_pulse(soft_reset_pulse), .buffer_state_wr(buffer_state_wr),
    .buffer_state_wdata(buffer_state_wdata),
    .sample_byte_pop(sample_byte_pop));
